// [core/alu_if.sv]
// Carrier between the execute block and its arithmetic unit.
interface alu_if;
  import exec_pkg::*;
  op_t op; // Operation to evaluate.
  logic [7:0] file_val; // Value read from the addressed file register.
  logic [7:0] accum; // Present accumulator.
  logic [7:0] literal; // Immediate byte.
  logic [7:0] result; // Eight-bit result.
  logic is_zero; // High when the result is zero.
  modport core (output op, output file_val, output accum, output literal,
    input result, input is_zero);
  modport unit (input op, input file_val, input accum, input literal,
    output result, output is_zero);
endinterface

// [core/exec_alu.sv]
// Arithmetic unit: decrement, increment and OR for the execute block.
module exec_alu
  import exec_pkg::*;
(
  alu_if.unit bus
);
  // Results are eight bits wide, so steps wrap modulo 256 by truncation.
  always_comb begin
    unique case (bus.op)
      OP_DECREMENT, OP_DECREMENT_SKIP: begin
        bus.result = bus.file_val - 8'h01;
      end
      OP_INCREMENT_SKIP: begin
        bus.result = bus.file_val + 8'h01;
      end
      OP_OR_LITERAL: begin
        bus.result = bus.accum | bus.literal;
      end
      default: begin
        bus.result = 8'h00;
      end
    endcase
    bus.is_zero = (bus.result == 8'h00);
  end
endmodule

// [core/exec_params.svh]
// Constants for the clear, step, jump and OR-literal execute block.
`ifndef EXEC_PARAMS_SVH
`define EXEC_PARAMS_SVH
// Reset values of the architectural state.
`define ACCUM_RESET 8'h00
`define PC_RESET 15'h0000
// Field positions of the jump target and the upper latch bits used.
`define JUMP_LO_MSB 10
`define LATCH_HI_MSB 6
`define LATCH_HI_LSB 3
// Destination bit value that selects the accumulator.
`define DEST_ACCUM 1'b0
`endif

// [core/exec_pkg.sv]
// Types shared by the execute block and its arithmetic unit.
package exec_pkg;
  // Operation selected by the decoder for the current instruction.
  typedef enum logic [2:0] {
    OP_IDLE,
    OP_CLEAR_REG,
    OP_DECREMENT,
    OP_CLEAR_ACCUM,
    OP_DECREMENT_SKIP,
    OP_INCREMENT_SKIP,
    OP_JUMP,
    OP_OR_LITERAL
  } op_t;

  // Complete state of the execute block.
  typedef struct packed {
    logic [7:0] accum;
    logic zero;
    logic [14:0] pc;
    logic squash;
    logic wr_en;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
  } exec_state_t;
endpackage

// [core/exec_unit.sv]
// Execute stage for clear, decrement, skip, jump and OR-literal.
`include "exec_params.svh"
// One instruction word may be presented on each clock with its file register
// already read. Its effects appear on the registered outputs one clock later.
// A skip whose result is zero, and every jump, flag the next presented word as
// flushed: that word still advances the program counter but changes nothing
// else, which is how those instructions come to cost two cycles. Writes to
// the file registers leave as a one-cycle strobe with address and data, so
// the register file itself stays outside this block. Call, return and the
// other instruction groups are decoded elsewhere and reach here as idle.
module exec_unit
  import exec_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic instr_valid_i,
  input wire op_t op_i,
  input wire logic [6:0] file_addr_i,
  input wire logic dest_i,
  input wire logic [10:0] immediate_i,
  input wire logic [7:0] file_rdata_i,
  input wire logic [7:0] upper_pc_latch_i,
  output logic [7:0] accum_o,
  output logic zero_o,
  output logic [14:0] pc_o,
  output logic flush_o,
  output logic file_wr_en_o,
  output logic [6:0] file_wr_addr_o,
  output logic [7:0] file_wr_data_o
);
  // Every architectural bit of the block lives in this one registered word, so
  // the reset value and the hand-over to the outputs are written in one place.
  exec_state_t state_reg; // Registered state, the source of every output.
  exec_state_t state_next; // Next state, built fresh each cycle below.
  // A word is executed only when it is present and its slot was not flushed by
  // the skip or jump before it; a flushed word still moves the counter.
  logic live; // Instruction accepted and not flushed.
  // The step and OR arithmetic sits in its own unit behind this carrier.
  alu_if alu_bus (); // Operands out, result and zero test back.

  // Arithmetic unit is purely combinational, so its result is ready in the same
  // cycle as the operands and adds no latency to the execute stage.
  exec_alu u_alu (
    .bus(alu_bus)
  );

  // Operands for the arithmetic unit. The file register is read in the same
  // cycle as the instruction, so the surrounding core presents it alongside.
  assign alu_bus.op = op_i; // Operation decides which result the unit forms.
  assign alu_bus.file_val = file_rdata_i; // Addressed file register contents.
  assign alu_bus.accum = state_reg.accum; // Present accumulator for the OR.
  // Only the low byte of the immediate is a literal; the upper three bits of
  // the field belong to jump targets and are ignored here.
  assign alu_bus.literal = immediate_i[7:0];
  // A pending flush turns the next presented word into a no-operation.
  assign live = instr_valid_i && !state_reg.squash;

  // Next-state logic. A flushed slot still advances the program counter,
  // which is what makes skip and jump cost one extra cycle.
  always_comb begin
    // Hold everything by default; only the write strobe is a one-cycle pulse.
    state_next = state_reg;
    state_next.wr_en = 1'b0;
    // Every presented word, executed or flushed, moves the counter on by one
    // and consumes any pending flush.
    if (instr_valid_i) begin
      state_next.pc = state_reg.pc + 15'h0001;
      state_next.squash = 1'b0;
    end
    // Executed words apply their own effect on top of the defaults above.
    if (live) begin
      unique case (op_i)
        // Clear a file register: write zero and set the flag regardless.
        OP_CLEAR_REG: begin
          state_next.wr_en = 1'b1;
          state_next.wr_addr = file_addr_i; // Any of the 128 file addresses.
          state_next.wr_data = 8'h00; // Written value is always zero.
          state_next.zero = 1'b1;
        end
        // The three step forms share the routing by the destination bit.
        OP_DECREMENT, OP_DECREMENT_SKIP, OP_INCREMENT_SKIP: begin
          // Destination bit chooses accumulator or file register.
          if (dest_i == `DEST_ACCUM) begin
            // Result goes to the accumulator; the file register is left alone.
            state_next.accum = alu_bus.result;
          end else begin
            // Result is written back over the operand it came from.
            state_next.wr_en = 1'b1;
            state_next.wr_addr = file_addr_i; // Same address as the read.
            state_next.wr_data = alu_bus.result; // Wrapped eight-bit step.
          end
          // Only plain decrement touches the flag; the skip forms leave it.
          if (op_i == OP_DECREMENT) begin
            // Plain decrement reports a zero result on the flag.
            state_next.zero = alu_bus.is_zero;
          end else begin
            // A zero result flushes the word already fetched behind this one.
            state_next.squash = alu_bus.is_zero;
          end
        end
        // Clear the accumulator; there is no operand to read.
        OP_CLEAR_ACCUM: begin
          state_next.accum = 8'h00;
          state_next.zero = 1'b1;
        end
        // Jump: the low eleven bits come from the word, the upper four from
        // the latch, so a target in another page needs the latch set first.
        OP_JUMP: begin
          // The fetched successor is stale, so it is flushed.
          state_next.pc = {upper_pc_latch_i[`LATCH_HI_MSB:`LATCH_HI_LSB],
            immediate_i[`JUMP_LO_MSB:0]};
          state_next.squash = 1'b1;
        end
        // OR the literal into the accumulator and report a zero result.
        OP_OR_LITERAL: begin
          state_next.accum = alu_bus.result;
          state_next.zero = alu_bus.is_zero;
        end
        // An idle word only advances the counter, which the defaults did.
        // Every code of the operation type is listed, so no default is needed.
        OP_IDLE: begin
          state_next.wr_en = 1'b0;
        end
      endcase
    end
  end

  // State register with synchronous reset. Reset clears the flush as well, so
  // the first word after reset is always executed. A synchronous reset keeps
  // the whole state on the one clock with no separate reset timing to close.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_reg <= '{accum: `ACCUM_RESET, zero: 1'b0, pc: `PC_RESET, squash: 1'b0,
        wr_en: 1'b0, wr_addr: 7'h00, wr_data: 8'h00};
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs come straight from the state register, so no output has a
  // combinational path from any input.
  assign accum_o = state_reg.accum; // Accumulator.
  assign zero_o = state_reg.zero; // Zero flag, high after a zero result of a clear, decrement or OR.
  assign pc_o = state_reg.pc; // Program counter.
  assign flush_o = state_reg.squash; // Next presented word becomes a no-operation.
  assign file_wr_en_o = state_reg.wr_en; // One-cycle write strobe.
  assign file_wr_addr_o = state_reg.wr_addr;
  assign file_wr_data_o = state_reg.wr_data;

  // Checks below all run on the core clock and stand down while reset is low.
  // Each watches the registered outputs one clock after the word was taken.
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  a_clear_reg_write: assert property (
    live && op_i == OP_CLEAR_REG |=> file_wr_en_o && file_wr_data_o == 8'h00
      && file_wr_addr_o == $past(file_addr_i) && zero_o)
    else $error("clear register did not write zero");
  a_decrement_route: assert property (
    live && op_i == OP_DECREMENT && dest_i |=> file_wr_en_o
      && file_wr_data_o == $past(file_rdata_i) - 8'h01
      && accum_o == $past(accum_o))
    else $error("decrement to file register wrong");
  a_clear_accum_zero: assert property (
    live && op_i == OP_CLEAR_ACCUM |=> accum_o == 8'h00 && zero_o && !file_wr_en_o)
    else $error("clear accumulator wrong");
  a_dec_skip_flush: assert property (
    live && op_i == OP_DECREMENT_SKIP |=> flush_o == ($past(file_rdata_i) == 8'h01)
      && zero_o == $past(zero_o))
    else $error("decrement skip flush wrong");
  a_inc_skip_flush: assert property (
    live && op_i == OP_INCREMENT_SKIP && !dest_i |=> flush_o == ($past(file_rdata_i)
      == 8'hFF) && accum_o == $past(file_rdata_i) + 8'h01 && zero_o == $past(zero_o))
    else $error("increment skip wrong");
  a_jump_target: assert property (
    live && op_i == OP_JUMP |=> pc_o == {$past(upper_pc_latch_i[6:3]),
      $past(immediate_i)} && flush_o)
    else $error("jump target wrong");
  a_flushed_slot_idle: assert property (
    flush_o && instr_valid_i |=> !file_wr_en_o && accum_o == $past(accum_o)
      && !flush_o)
    else $error("flushed slot changed state");
  a_or_literal_acc: assert property (
    live && op_i == OP_OR_LITERAL |=> accum_o == ($past(accum_o)
      | $past(immediate_i[7:0])) && zero_o == (accum_o == 8'h00))
    else $error("or literal wrong");
  a_zero_on_dec: assert property (
    live && op_i == OP_DECREMENT && !dest_i |=> zero_o == ($past(file_rdata_i) == 8'h01))
    else $error("zero flag after decrement wrong");
  a_clear_reg_accum: assert property (
    live && op_i == OP_CLEAR_REG |=> accum_o == $past(accum_o))
    else $error("clear register changed the accumulator");
  a_or_no_write: assert property (
    live && op_i == OP_OR_LITERAL |=> !file_wr_en_o && !flush_o)
    else $error("or literal wrote a file register or flushed");
  // Skip routing to the file register and to the accumulator.
  a_skip_file_write: assert property (
    live && (op_i == OP_DECREMENT_SKIP || op_i == OP_INCREMENT_SKIP) && dest_i
      |=> file_wr_en_o && file_wr_addr_o == $past(file_addr_i)
      && accum_o == $past(accum_o))
    else $error("skip step not written back to file register");
  a_dec_skip_accum: assert property (
    live && op_i == OP_DECREMENT_SKIP && !dest_i |=> !file_wr_en_o
      && accum_o == $past(file_rdata_i) - 8'h01)
    else $error("decrement skip to accumulator wrong");
  // A jump moves only the counter and raises the flush.
  a_jump_keeps_flag: assert property (
    live && op_i == OP_JUMP |=> zero_o == $past(zero_o)
      && accum_o == $past(accum_o) && !file_wr_en_o)
    else $error("jump changed data state");
  // Counter and idle behaviour common to every operation except an executed jump.
  a_pc_step_word: assert property (
    instr_valid_i && !(live && op_i == OP_JUMP) |=> pc_o == $past(pc_o) + 15'h0001)
    else $error("program counter did not step by one");
  a_idle_holds_state: assert property (
    !instr_valid_i |=> pc_o == $past(pc_o) && flush_o == $past(flush_o)
      && accum_o == $past(accum_o) && zero_o == $past(zero_o) && !file_wr_en_o)
    else $error("state changed without an instruction");

  // Main scenarios: a taken skip, a flushed slot after a jump, an increment
  // that wraps to zero and an OR that leaves the accumulator at zero.
  c_skip_taken: cover property (live && op_i == OP_DECREMENT_SKIP ##1 flush_o);
  c_jump_taken: cover property (live && op_i == OP_JUMP ##2 flush_o && instr_valid_i);
  c_inc_wrap: cover property (live && op_i == OP_INCREMENT_SKIP
    && file_rdata_i == 8'hFF);
  c_or_zero: cover property (live && op_i == OP_OR_LITERAL ##1 zero_o);
endmodule

// [verif/tb.sv]
// Self-checking bench for the clear, step, skip, jump and OR-literal execute block.
module tb import exec_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic instr_valid_i = 1'b0;
  op_t op_i = OP_IDLE;
  logic [6:0] file_addr_i = 7'h00;
  logic dest_i = 1'b0;
  logic [10:0] immediate_i = 11'h000;
  logic [7:0] file_rdata_i = 8'h00;
  logic [7:0] upper_pc_latch_i = 8'h00;
  logic [7:0] accum_o;
  logic zero_o;
  logic [14:0] pc_o;
  logic flush_o;
  logic file_wr_en_o;
  logic [6:0] file_wr_addr_o;
  logic [7:0] file_wr_data_o;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [14:0] exp_pc = 15'h0000; // Counter model, advanced once per taken word.
  exec_unit dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i),
    .op_i(op_i), .file_addr_i(file_addr_i), .dest_i(dest_i), .immediate_i(immediate_i),
    .file_rdata_i(file_rdata_i), .upper_pc_latch_i(upper_pc_latch_i), .accum_o(accum_o),
    .zero_o(zero_o), .pc_o(pc_o), .flush_o(flush_o), .file_wr_en_o(file_wr_en_o),
    .file_wr_addr_o(file_wr_addr_o), .file_wr_data_o(file_wr_data_o));
  // Free-running 40 MHz clock.
  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // A hang is cut short well above the fifty or so cycles the tests need.
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      conclude();
    end
  end
  // Compares one value, counting the check.
  task automatic chk(input logic [14:0] got, input logic [14:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Checks all outputs; address and data only matter while a write is flagged.
  task automatic ex(input logic [7:0] a, input logic z, input logic f, input logic w,
      input logic [6:0] wa, input logic [7:0] wd);
    chk({7'h00, accum_o}, {7'h00, a});
    chk({14'h0000, zero_o}, {14'h0000, z});
    chk({14'h0000, flush_o}, {14'h0000, f});
    chk(pc_o, exp_pc);
    chk({14'h0000, file_wr_en_o}, {14'h0000, w});
    if (w) chk({file_wr_data_o, file_wr_addr_o}, {wd, wa});
  endtask
  // Presents one word for one edge, then drops valid and garbles the read data.
  task automatic issue(input op_t op, input logic [6:0] fa, input logic d,
      input logic [10:0] k, input logic [7:0] rd);
    @(posedge clk_sys_i);
    instr_valid_i <= 1'b1;
    op_i <= op;
    file_addr_i <= fa;
    dest_i <= d;
    immediate_i <= k;
    file_rdata_i <= rd;
    @(posedge clk_sys_i);
    instr_valid_i <= 1'b0;
    file_rdata_i <= ~rd;
    #1;
    exp_pc = exp_pc + 15'h0001;
  endtask
  task automatic t_clear;
    issue(OP_OR_LITERAL, 7'h00, 1'b0, 11'h75A, 8'h00);
    ex(8'h5A, 1'b0, 1'b0, 1'b0, 7'h00, 8'h00);
    issue(OP_CLEAR_REG, 7'h7F, 1'b0, 11'h000, 8'h33);
    ex(8'h5A, 1'b1, 1'b0, 1'b1, 7'h7F, 8'h00);
    issue(OP_OR_LITERAL, 7'h00, 1'b0, 11'h000, 8'h00);
    ex(8'h5A, 1'b0, 1'b0, 1'b0, 7'h00, 8'h00);
    issue(OP_CLEAR_ACCUM, 7'h00, 1'b0, 11'h000, 8'h44);
    ex(8'h00, 1'b1, 1'b0, 1'b0, 7'h00, 8'h00);
    $display("done clear");
  endtask
  task automatic t_dec;
    issue(OP_DECREMENT, 7'h05, 1'b0, 11'h000, 8'h01);
    ex(8'h00, 1'b1, 1'b0, 1'b0, 7'h00, 8'h00);
    issue(OP_DECREMENT, 7'h06, 1'b1, 11'h000, 8'h00);
    ex(8'h00, 1'b0, 1'b0, 1'b1, 7'h06, 8'hFF);
    issue(OP_DECREMENT, 7'h07, 1'b0, 11'h000, 8'h80);
    ex(8'h7F, 1'b0, 1'b0, 1'b0, 7'h00, 8'h00);
    $display("done decrement");
  endtask
  // Skips must leave the zero flag alone even when the result is zero.
  task automatic t_skip;
    issue(OP_DECREMENT_SKIP, 7'h10, 1'b1, 11'h000, 8'h01);
    ex(8'h7F, 1'b0, 1'b1, 1'b1, 7'h10, 8'h00);
    issue(OP_OR_LITERAL, 7'h00, 1'b0, 11'h0FF, 8'h00);
    ex(8'h7F, 1'b0, 1'b0, 1'b0, 7'h00, 8'h00);
    issue(OP_INCREMENT_SKIP, 7'h11, 1'b0, 11'h000, 8'hFF);
    ex(8'h00, 1'b0, 1'b1, 1'b0, 7'h00, 8'h00);
    issue(OP_CLEAR_REG, 7'h12, 1'b0, 11'h000, 8'h00);
    ex(8'h00, 1'b0, 1'b0, 1'b0, 7'h00, 8'h00);
    issue(OP_INCREMENT_SKIP, 7'h13, 1'b1, 11'h000, 8'h05);
    ex(8'h00, 1'b0, 1'b0, 1'b1, 7'h13, 8'h06);
    issue(OP_DECREMENT_SKIP, 7'h14, 1'b0, 11'h000, 8'h03);
    ex(8'h02, 1'b0, 1'b0, 1'b0, 7'h00, 8'h00);
    $display("done skip");
  endtask
  // Latch bit 7 and bits 2:0 are set to prove they are ignored.
  task automatic t_jump;
    @(posedge clk_sys_i);
    upper_pc_latch_i <= 8'hAF;
    issue(OP_JUMP, 7'h00, 1'b0, 11'h7FF, 8'h00);
    exp_pc = 15'h2FFF;
    ex(8'h02, 1'b0, 1'b1, 1'b0, 7'h00, 8'h00);
    issue(OP_CLEAR_ACCUM, 7'h00, 1'b0, 11'h000, 8'h00);
    ex(8'h02, 1'b0, 1'b0, 1'b0, 7'h00, 8'h00);
    @(posedge clk_sys_i);
    upper_pc_latch_i <= 8'hD7;
    issue(OP_JUMP, 7'h00, 1'b0, 11'h400, 8'h00);
    exp_pc = 15'h5400;
    ex(8'h02, 1'b0, 1'b1, 1'b0, 7'h00, 8'h00);
    $display("done jump");
  endtask
  task automatic t_or;
    issue(OP_IDLE, 7'h00, 1'b0, 11'h000, 8'h00);
    issue(OP_OR_LITERAL, 7'h00, 1'b0, 11'h081, 8'h00);
    ex(8'h83, 1'b0, 1'b0, 1'b0, 7'h00, 8'h00);
    issue(OP_CLEAR_ACCUM, 7'h00, 1'b0, 11'h000, 8'h00);
    issue(OP_OR_LITERAL, 7'h00, 1'b0, 11'h700, 8'h00);
    ex(8'h00, 1'b1, 1'b0, 1'b0, 7'h00, 8'h00);
    $display("done or");
  endtask
  // Main sequence: two reset edges, reset state, then each scenario.
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    #1;
    ex(8'h00, 1'b0, 1'b0, 1'b0, 7'h00, 8'h00);
    t_clear();
    t_dec();
    t_skip();
    t_jump();
    t_or();
    conclude();
  end
endmodule
